/* File: irq_ctrl_pkg.sv */
// Shared constants and carriers for the two-level interrupt controller.
// Assumes a single 40 MHz system clock and an external CPU sequencer.
package irq_ctrl_pkg;
  localparam int NUM_SRC = 23;
  localparam int SRC_W = 5;
  localparam int VEC_W = 16;
  localparam logic [VEC_W-1:0] RESET_VECTOR = 16'h0000;
  localparam logic [VEC_W-1:0] VECTOR_BASE = 16'h0003;
  localparam logic [VEC_W-1:0] VECTOR_STEP = 16'h0008;
  // Order 15 is marked unused, but the vector table still fills its slot
  localparam int UNUSED_ORDER = 15;
  localparam int CLK_MHZ = 40;
  localparam int DETECT_CYCLES = 1;
  localparam int CALL_CYCLES = 4;
  localparam int RETURN_CYCLES = 5;
  localparam int DIV_CYCLES = 8;
  localparam int MIN_RESPONSE = DETECT_CYCLES + CALL_CYCLES;
  localparam int MAX_RESPONSE = DETECT_CYCLES + RETURN_CYCLES + DIV_CYCLES + CALL_CYCLES;
  // Sources whose pending flag hardware clears on vectoring
  localparam logic [NUM_SRC-1:0] HW_CLEAR_MASK = 23'h00000F;
  localparam logic [NUM_SRC-1:0] ENABLE_RESET = 23'h000000;
  localparam logic [NUM_SRC-1:0] LEVEL_RESET = 23'h000000;
  localparam logic GLOBAL_ENABLE_RESET = 1'b0;

  typedef struct packed {
    logic valid;
    logic high;
    logic [SRC_W-1:0] src;
    logic [VEC_W-1:0] vector;
  } irq_req_t;

  typedef struct packed {
    logic instr_done;
    logic call_taken;
    logic return_done;
  } cpu_evt_t;
endpackage

/* File: two_level_interrupt_controller.sv */
// Two-level vectored interrupt controller: pending flags, enables, priorities, nesting.
// Assumes the CPU sequencer pulses its events for one clock and runs the long call itself.
// How it works
// - A valid source condition sets that source's pending flag to one.
// - Flags set regardless of individual or global enable.
// - Enabled set flag raises a request; CPU long-calls its vector after current instruction.
// - Return resumes the interrupted flow; controller unwinds its nesting state and sets its post-return hold.
// - Flags of disabled sources raise no request.
// - Each source owns one enable bit in standard or extended enable registers.
// - Individual enables act only while global enable is one.
// - Global enable zero blocks every source.
// - Flags of sources 0..3 clear on vectoring; software clears the rest.
// - A flag still set after return requests again once one more instruction completes.
// - Software writing one to a flag acts like a hardware event.
// - Per-source level bit, default low; high preempts low, high never preempted.
// - Simultaneous requests: high level served before low.
// - Within a level, lowest order number wins, order 0 to 22.
// - Requests sampled and decoded every clock; least response five cycles.
// - After a return, one more instruction completes before the next call.
// - Worst response eighteen clocks, including return and a divide.
// - Equal or lower level waits for return plus one instruction.
// - On exit the highest-priority pending request is chosen next.
// - Fixed vectors: reset zero, source n at 0x0003 plus eight per order.
// - Level per source set through standard or extended level registers.
`timescale 1ns/1ps
module two_level_interrupt_controller #(
  parameter int NUM_SRC = irq_ctrl_pkg::NUM_SRC
) (
  // Clock and reset
  input wire logic clk_sys_in,
  input wire logic reset_n_in,
  // Source conditions and software flag access
  input wire logic [NUM_SRC-1:0] src_event_in,
  input wire logic [NUM_SRC-1:0] sw_flag_set_in,
  input wire logic [NUM_SRC-1:0] sw_flag_clr_in,
  // Enable and level configuration writes
  input wire logic enable_wr_in,
  input wire logic [NUM_SRC-1:0] enable_wdata_in,
  input wire logic global_enable_wr_in,
  input wire logic global_enable_wdata_in,
  input wire logic level_wr_in,
  input wire logic [NUM_SRC-1:0] level_wdata_in,
  // CPU sequencer events
  input wire irq_ctrl_pkg::cpu_evt_t cpu_evt_in,
  // Request to CPU
  output irq_ctrl_pkg::irq_req_t irq_req_out,
  // Status
  output logic [NUM_SRC-1:0] pending_out,
  output logic [NUM_SRC-1:0] enable_out,
  output logic [NUM_SRC-1:0] level_out,
  output logic global_enable_out,
  output logic [1:0] in_service_out,
  output logic hold_after_return_out
);

  logic [NUM_SRC-1:0] pending_ff;
  logic [NUM_SRC-1:0] enable_ff;
  logic [NUM_SRC-1:0] level_ff;
  logic global_enable_ff;
  // Nesting depth; high can only stack on top of low, never the other way round
  typedef enum logic [1:0] {NEST_IDLE, NEST_LOW, NEST_HIGH, NEST_BOTH} nest_state_t;
  nest_state_t nest_ff;
  logic in_service_low;
  logic in_service_high;
  logic hold_ff;
  irq_ctrl_pkg::irq_req_t req_ff;
  irq_ctrl_pkg::irq_req_t nxt_req;
  logic [NUM_SRC-1:0] armed;
  logic [NUM_SRC-1:0] call_clear;
  logic [NUM_SRC-1:0] win_high;
  logic [NUM_SRC-1:0] win_low;
  logic allow_high;
  logic allow_low;
  logic [irq_ctrl_pkg::VEC_W-1:0] vec_table [NUM_SRC];
  logic high_found;
  logic low_found;
  logic [irq_ctrl_pkg::SRC_W-1:0] high_src;
  logic [irq_ctrl_pkg::SRC_W-1:0] low_src;

  // Individual enables, one bit per source, all replaced by one write
  always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      enable_ff <= irq_ctrl_pkg::ENABLE_RESET;
    end else if (enable_wr_in) begin
      enable_ff <= enable_wdata_in;
    end
  end

  // Priority levels, one bit per source, low after reset
  always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      level_ff <= irq_ctrl_pkg::LEVEL_RESET;
    end else if (level_wr_in) begin
      level_ff <= level_wdata_in;
    end
  end

  // Global enable, off after reset so no source fires before software is ready
  always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      global_enable_ff <= irq_ctrl_pkg::GLOBAL_ENABLE_RESET;
    end else if (global_enable_wr_in) begin
      global_enable_ff <= global_enable_wdata_in;
    end
  end

  // Vectored source is cleared only for the auto-clear group
  always_comb begin
    call_clear = '0;
    if (cpu_evt_in.call_taken && req_ff.valid) begin
      call_clear[req_ff.src] = irq_ctrl_pkg::HW_CLEAR_MASK[req_ff.src];
    end
  end

  // Pending flags, one per source; a new event wins over any clear in the same cycle
  generate
    for (genvar i = 0; i < NUM_SRC; i++) begin : g_flag
      always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
          pending_ff[i] <= 1'b0;
        end else if (src_event_in[i] || sw_flag_set_in[i]) begin
          pending_ff[i] <= 1'b1;
        end else if (sw_flag_clr_in[i] || call_clear[i]) begin
          pending_ff[i] <= 1'b0;
        end
      end
    end
  endgenerate

  // Fixed vector per order; the slot of the unused order 15 is filled and selectable like any other
  generate
    for (genvar i = 0; i < NUM_SRC; i++) begin : g_vec
      assign vec_table[i] = irq_ctrl_pkg::VECTOR_BASE
                            + irq_ctrl_pkg::VECTOR_STEP * irq_ctrl_pkg::VEC_W'(i);
    end
  endgenerate

  // Gate flags by individual and global enables
  assign armed = global_enable_ff ? (pending_ff & enable_ff) : '0;

  // Lowest order wins within each level
  generate
    for (genvar i = 0; i < NUM_SRC; i++) begin : g_arb
      if (i == 0) begin : g_first
        assign win_high[i] = armed[i] & level_ff[i];
        assign win_low[i] = armed[i] & ~level_ff[i];
      end else begin : g_rest
        assign win_high[i] = armed[i] & level_ff[i] & ~|(armed[i-1:0] & level_ff[i-1:0]);
        assign win_low[i] = armed[i] & ~level_ff[i] & ~|(armed[i-1:0] & ~level_ff[i-1:0]);
      end
    end
  endgenerate

  // High may preempt low only; nothing preempts high; low waits for any routine
  assign allow_high = !in_service_high && !hold_ff;
  assign allow_low = !in_service_high && !in_service_low && !hold_ff;

  // Encode the single high-level winner into its order number
  always_comb begin
    high_found = 1'b0;
    high_src = '0;
    for (int i = 0; i < NUM_SRC; i++) begin
      if (win_high[i]) begin
        high_found = 1'b1;
        high_src = irq_ctrl_pkg::SRC_W'(i);
      end
    end
  end

  // Encode the single low-level winner into its order number
  always_comb begin
    low_found = 1'b0;
    low_src = '0;
    for (int i = 0; i < NUM_SRC; i++) begin
      if (win_low[i]) begin
        low_found = 1'b1;
        low_src = irq_ctrl_pkg::SRC_W'(i);
      end
    end
  end

  // Decode every clock, high level first
  always_comb begin
    nxt_req = '0;
    nxt_req.vector = irq_ctrl_pkg::RESET_VECTOR;
    if (high_found && allow_high) begin
      nxt_req.valid = 1'b1;
      nxt_req.high = 1'b1;
      nxt_req.src = high_src;
    end else if (low_found && allow_low) begin
      nxt_req.valid = 1'b1;
      nxt_req.high = 1'b0;
      nxt_req.src = low_src;
    end
    if (nxt_req.valid) begin
      // Vector 0 stays on the bus while idle, so a stray call lands on the reset entry
      nxt_req.vector = vec_table[nxt_req.src];
    end
    // A call taken this cycle retires the request on the same edge that an auto-clear flag drops
    if (cpu_evt_in.call_taken) begin
      nxt_req = '0;
    end
  end

  // Registered request; one cycle of detect latency
  always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      req_ff <= '0;
    end else begin
      req_ff <= nxt_req;
    end
  end

  // In-service markers per level; a call in the same cycle as a return wins
  always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      nest_ff <= NEST_IDLE;
    end else begin
      case (nest_ff)
        NEST_IDLE: begin
          if (cpu_evt_in.call_taken && req_ff.valid) begin
            nest_ff <= req_ff.high ? NEST_HIGH : NEST_LOW;
          end
        end
        NEST_LOW: begin
          if (cpu_evt_in.call_taken && req_ff.valid && req_ff.high) begin
            nest_ff <= NEST_BOTH;
          end else if (cpu_evt_in.return_done) begin
            nest_ff <= NEST_IDLE;
          end
        end
        NEST_HIGH: begin
          if (cpu_evt_in.return_done) begin
            nest_ff <= NEST_IDLE;
          end
        end
        NEST_BOTH: begin
          // Unwind the innermost level first
          if (cpu_evt_in.return_done) begin
            nest_ff <= NEST_LOW;
          end
        end
        default: begin
          nest_ff <= NEST_IDLE;
        end
      endcase
    end
  end

  assign in_service_low = (nest_ff == NEST_LOW) || (nest_ff == NEST_BOTH);
  assign in_service_high = (nest_ff == NEST_HIGH) || (nest_ff == NEST_BOTH);

  // After a return one more instruction must complete before the next call
  always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      hold_ff <= 1'b0;
    end else if (cpu_evt_in.return_done) begin
      hold_ff <= 1'b1;
    end else if (cpu_evt_in.instr_done) begin
      hold_ff <= 1'b0;
    end
  end

  assign irq_req_out = req_ff;
  assign pending_out = pending_ff;
  assign enable_out = enable_ff;
  assign level_out = level_ff;
  assign global_enable_out = global_enable_ff;
  assign in_service_out = {in_service_high, in_service_low};
  assign hold_after_return_out = hold_ff;

endmodule // two_level_interrupt_controller

/* File: irq_ctrl_sva.sv */
// Port checker for the two-level interrupt controller.
// Assumes binding into every controller instance.
`timescale 1ns/1ps
module irq_ctrl_sva #(parameter int NUM_SRC = irq_ctrl_pkg::NUM_SRC) (
  input logic clk_sys_in, reset_n_in, enable_wr_in, global_enable_wr_in, global_enable_wdata_in, level_wr_in,
  input logic [NUM_SRC-1:0] src_event_in, sw_flag_set_in, sw_flag_clr_in, enable_wdata_in, level_wdata_in,
  input irq_ctrl_pkg::cpu_evt_t cpu_evt_in,
  input irq_ctrl_pkg::irq_req_t irq_req_out,
  input logic [NUM_SRC-1:0] pending_out, enable_out, level_out,
  input logic global_enable_out, hold_after_return_out,
  input logic [1:0] in_service_out
);
  default clocking @(posedge clk_sys_in); endclocking
  default disable iff (!reset_n_in);
  // Auto-cleared flags are left out, although a set wins over the vector call clear
  wire logic [NUM_SRC-1:0] mask_w = ~irq_ctrl_pkg::HW_CLEAR_MASK;
  wire logic [NUM_SRC-1:0] live_w = pending_out & enable_out;
  wire logic [NUM_SRC-1:0] below_w = (NUM_SRC'(1) << irq_req_out.src) - NUM_SRC'(1);
  wire logic [NUM_SRC-1:0] same_w = ~(level_out ^ {NUM_SRC{irq_req_out.high}});
  flag_set_a: assert property (|(src_event_in & mask_w) |=>
    (pending_out & $past(src_event_in & mask_w)) == $past(src_event_in & mask_w)) else $error("flag not set");
  global_off_a: assert property (!global_enable_out && !$past(global_enable_out) |->
    !irq_req_out.valid) else $error("request with global enable off");
  disabled_a: assert property (irq_req_out.valid && $stable(live_w) && $stable(global_enable_out) |->
    live_w[irq_req_out.src] && global_enable_out) else $error("request from disabled source");
  vector_map_a: assert property (irq_req_out.valid |->
    irq_req_out.vector == 16'h0003 + {8'h00, irq_req_out.src, 3'h0}) else $error("wrong vector");
  same_level_a: assert property (irq_req_out.valid && $stable(live_w) && $stable(level_out) |->
    (live_w & same_w & below_w) == '0) else $error("order not kept");
  high_first_a: assert property (irq_req_out.valid && !irq_req_out.high && $stable(live_w) && $stable(level_out) |->
    (live_w & level_out) == '0) else $error("low served before high");
  no_preempt_a: assert property (in_service_out[1] |-> !irq_req_out.valid) else $error("high preempted");
  hw_clear_a: assert property (cpu_evt_in.call_taken && irq_req_out.valid && irq_req_out.src < 5'h4 &&
    !src_event_in[irq_req_out.src] && !sw_flag_set_in[irq_req_out.src] |=> !pending_out[$past(irq_req_out.src)])
    else $error("flag not cleared on call");
  in_service_a: assert property (cpu_evt_in.call_taken && irq_req_out.valid |=>
    in_service_out[$past(irq_req_out.high)]) else $error("marker not set");
  cover property (irq_req_out.valid && irq_req_out.high);
  cover property (in_service_out == 2'h3);
  cover property (hold_after_return_out);
endmodule // irq_ctrl_sva
bind two_level_interrupt_controller irq_ctrl_sva #(.NUM_SRC(NUM_SRC)) u_irq_ctrl_sva (.clk_sys_in, .reset_n_in,
  .enable_wr_in, .global_enable_wr_in, .global_enable_wdata_in, .level_wr_in, .src_event_in, .sw_flag_set_in,
  .sw_flag_clr_in, .enable_wdata_in, .level_wdata_in, .cpu_evt_in, .irq_req_out, .pending_out, .enable_out,
  .level_out, .global_enable_out, .hold_after_return_out, .in_service_out);

/* File: cpu_model.sv */
// CPU sequencer model: takes requests, returns on command, retires instructions.
// Assumes the bench raises the return command only while a routine runs.
`timescale 1ns/1ps
module cpu_model (
  input wire logic clk_sys_in,
  input wire logic reset_n_in,
  input wire irq_ctrl_pkg::irq_req_t irq_req_out,
  input wire logic ret_cmd_in,
  output irq_ctrl_pkg::cpu_evt_t cpu_evt_out
);
  logic [1:0] step_ff;
  always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      cpu_evt_out <= '0;
      step_ff <= 2'h0;
    end else begin
      step_ff <= step_ff + 2'h1;
      cpu_evt_out.call_taken <= irq_req_out.valid && !cpu_evt_out.call_taken;
      cpu_evt_out.return_done <= ret_cmd_in;
      // Instructions retire every fourth cycle, so the hold after a return lasts a while
      cpu_evt_out.instr_done <= step_ff == 2'h3;
    end
  end
endmodule // cpu_model

/* File: two_level_interrupt_controller_tb.sv */
// Testbench for the two-level interrupt controller.
// Assumes the CPU model and the bound checker are compiled first.
`timescale 1ns/1ps
module two_level_interrupt_controller_tb;
  logic clk_sys_in = 1'b0, reset_n_in = 1'b0, ret_cmd = 1'b0;
  logic enable_wr_in = 1'b0, global_enable_wr_in = 1'b0, global_enable_wdata_in = 1'b0, level_wr_in = 1'b0;
  logic [22:0] src_event_in = '0, sw_flag_set_in = '0, sw_flag_clr_in = '0, enable_wdata_in = '0, level_wdata_in = '0;
  irq_ctrl_pkg::cpu_evt_t cpu_evt_in;
  irq_ctrl_pkg::irq_req_t irq_req_out;
  logic [22:0] pending_out, enable_out, level_out;
  logic global_enable_out, hold_after_return_out;
  logic [1:0] in_service_out;
  int err_count = 0, checks = 0, cycles = 0;
  always #12.5 clk_sys_in = ~clk_sys_in;
  two_level_interrupt_controller u_two_level_interrupt_controller (.clk_sys_in, .reset_n_in, .src_event_in,
    .sw_flag_set_in, .sw_flag_clr_in, .enable_wr_in, .enable_wdata_in, .global_enable_wr_in, .global_enable_wdata_in,
    .level_wr_in, .level_wdata_in, .cpu_evt_in, .irq_req_out, .pending_out, .enable_out, .level_out,
    .global_enable_out, .in_service_out, .hold_after_return_out);
  cpu_model u_cpu_model (.clk_sys_in, .reset_n_in, .irq_req_out, .ret_cmd_in(ret_cmd), .cpu_evt_out(cpu_evt_in));
  task automatic step(input int n);
    repeat (n) @(negedge clk_sys_in);
  endtask
  task automatic cmp(input logic [22:0] got, input logic [22:0] exp);
    checks++;
    if (got !== exp) begin
      err_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic fire(input logic [22:0] ev, input logic [22:0] sw);
    src_event_in = ev;
    sw_flag_set_in = sw;
    step(1);
    src_event_in = '0;
    sw_flag_set_in = '0;
  endtask
  task automatic wr(input logic [2:0] sel, input logic [22:0] d);
    {enable_wr_in, level_wr_in, global_enable_wr_in} = sel;
    enable_wdata_in = d;
    level_wdata_in = d;
    global_enable_wdata_in = d[0];
    step(1);
    {enable_wr_in, level_wr_in, global_enable_wr_in} = 3'h0;
  endtask
  task automatic ret();
    ret_cmd = 1'b1;
    step(1);
    ret_cmd = 1'b0;
    step(1);
  endtask
  // Bounded wait, then level, order and vector are compared, vector worked out from the order
  task automatic wait_req(input logic [4:0] src, input logic hi);
    int n;
    n = 0;
    while (irq_req_out.valid !== 1'b1 && n < 20) begin
      step(1);
      n++;
    end
    cmp({irq_req_out.high, irq_req_out.src, irq_req_out.vector}, {hi, src, 16'h0003 + {8'h00, src, 3'h0}});
    step(3);
  endtask
  task automatic stop_test();
    $display("checks %0d errors %0d", checks, err_count);
    if (err_count == 0 && checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  always @(posedge clk_sys_in) begin
    cycles++;
    if (cycles == 2000) begin
      err_count++;
      stop_test();
    end
  end
  initial begin
    step(6);
    reset_n_in = 1'b1;
    step(1);
    cmp(enable_out | level_out | pending_out | {global_enable_out, in_service_out}, '0);
    fire(23'h000020, '0);
    step(1);
    cmp(pending_out, 23'h000020);
    wr(3'h4, 23'h7FFFFF);
    step(2);
    cmp(irq_req_out.valid, 1'b0);
    wr(3'h1, 23'h000001);
    wait_req(5'h05, 1'b0);
    cmp(pending_out, 23'h000020);
    cmp(in_service_out, 2'h1);
    wr(3'h2, 23'h400001);
    fire(23'h400003, '0);
    step(1);
    cmp(irq_req_out.valid, 1'b1);
    wait_req(5'h00, 1'b1);
    cmp(in_service_out, 2'h3);
    cmp(pending_out, 23'h400022);
    cmp(irq_req_out.valid, 1'b0);
    ret();
    cmp(in_service_out, 2'h1);
    wait_req(5'h16, 1'b1);
    sw_flag_clr_in = 23'h400000;
    step(1);
    sw_flag_clr_in = '0;
    ret();
    ret();
    cmp(in_service_out, 2'h0);
    wait_req(5'h01, 1'b0);
    cmp(pending_out, 23'h000020);
    ret();
    wait_req(5'h05, 1'b0);
    fire('0, 23'h010000);
    step(1);
    cmp(irq_req_out.valid, 1'b0);
    sw_flag_clr_in = 23'h000020;
    step(1);
    sw_flag_clr_in = '0;
    ret();
    wait_req(5'h10, 1'b0);
    ret();
    wr(3'h4, 23'h000000);
    step(8);
    cmp(irq_req_out.valid, 1'b0);
    stop_test();
  end
endmodule // two_level_interrupt_controller_tb
